// ==== pkg/cop_watchdog_enable_clear_bit_cfg.svh ====
`ifndef COP_WATCHDOG_ENABLE_CLEAR_BIT_CFG_SVH
`define COP_WATCHDOG_ENABLE_CLEAR_BIT_CFG_SVH

// ----------------------------------------------------------------
// Register map (byte addresses on the Avalon-MM slave)
// ----------------------------------------------------------------
`define MISC_OFFSET 4'h0
`define STAT_OFFSET 4'h4

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define MISC_WATCHDOG_ENABLE_CLEAR_BIT_BIT 0
`define MISC_SLOW_BIT 1
`define MISC_IRQEN_BIT 4
`define MISC_POR_BIT 7

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define STAT_CNT_LSB 0
`define STAT_CNT_MSB 2
`define STAT_PIN_BIT 3
`define STAT_WDRST_BIT 4
`define STAT_STOPRST_BIT 5
`define STAT_EN_BIT 6

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLOCK_PERIOD_NS 25
`define MACHINE_CYCLE_NS 25
`define EXT_LOW_MIN_TENTH_CYC 15
`define EXT_LOW_MIN_CYC ((`EXT_LOW_MIN_TENTH_CYC * `MACHINE_CYCLE_NS + 10 * `CLOCK_PERIOD_NS - 1) / (10 * `CLOCK_PERIOD_NS))
`define STARTUP_LONG_CYC 4064
`define STARTUP_SHORT_CYC 16

// ----------------------------------------------------------------
// Watchdog chain and reset values
// ----------------------------------------------------------------
`define PRESC_BITS 10
`define DIV8_FINAL 3'h7
`define TIMER_LOAD 16'hfffc
`define STACK_INIT 8'hff
`define START_VECTOR 16'h1ffe

`endif

// ==== pkg/cop_watchdog_enable_clear_bit_pkg.sv ====
package cop_watchdog_enable_clear_bit_pkg;

  typedef enum logic [2:0] {
    st_por,
    st_run,
    st_drive,
    st_ext,
    st_stop,
    st_wake
  } ctrl_state_type;

  typedef struct packed {
    logic timer_reset;
    logic cpu_restart;
    logic serial_reset;
    logic osc_off;
    logic clk_clear;
    logic analog_nvm_reset;
    logic i_bit_clear;
    logic [15:0] timer_load;
    logic [7:0] stack_init;
    logic [15:0] start_vector;
  } reset_effects_type;

endpackage

// ==== rtl/sync_2ff.sv ====
`timescale 1ns/1ps
module sync_2ff #(
  parameter bit RESET_VAL = 1'b1
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic d,
  output logic q
);
  logic meta_r;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta_r <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ==== rtl/cop_watchdog_reset_control.sv ====
`timescale 1ns/1ps
`include "cop_watchdog_enable_clear_bit_cfg.svh"
module cop_watchdog_reset_control #(
  parameter bit AUTO_ENABLE = 1'b0,
  parameter bit WAIT_HALTS = 1'b0,
  parameter bit LONG_STARTUP = 1'b1,
  parameter int unsigned DOG_LOW_HOLD_CYC = 2
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe_n,
  input wire logic timer_carry7,
  input wire logic stop_exec,
  input wire logic stop_wake,
  input wire logic wait_active,
  output logic chip_reset,
  output logic slow_mode_bit,
  output logic ext_irq_enable,
  output cop_watchdog_enable_clear_bit_pkg::reset_effects_type effects
);
  import cop_watchdog_enable_clear_bit_pkg::*;

  // ----------------------------------------------------------------
  // Constants
  // ----------------------------------------------------------------
  localparam logic [11:0] STARTUP_CYC =
    LONG_STARTUP ? 12'(`STARTUP_LONG_CYC) : 12'(`STARTUP_SHORT_CYC);
  localparam logic [11:0] STOP_WAKE_CYC = 12'(`STARTUP_LONG_CYC);
  localparam logic [11:0] EXT_MIN_CYC = 12'(`EXT_LOW_MIN_CYC);
  localparam logic [11:0] HOLD_CYC = 12'(DOG_LOW_HOLD_CYC);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  ctrl_state_type state_r;
  logic [11:0] delay_r;
  logic pin_sync;
  logic ack_r;
  logic [31:0] readdata_r;
  logic watchdog_enable_clear_bit_en_r;
  logic [`PRESC_BITS-1:0] presc_r;
  logic [2:0] div8_r;
  logic por_flag_r;
  logic slow_mode_r;
  logic ext_irq_en_r;
  logic watchdog_enable_clear_bit_cause_r;
  logic stop_cause_r;
  logic wait_d_r;
  reset_effects_type effects_r;
  reset_effects_type effects_nxt;
  logic in_reset;
  logic pin_drive;
  logic running;
  logic wr_ok;
  logic misc_wr;
  logic watchdog_enable_clear_bit_write1;
  logic wait_enter;
  logic halted;
  logic tick;
  logic dog_fire;
  logic stop_fire;
  logic stop_sleep;
  logic stop_phase;

  // ----------------------------------------------------------------
  // Reset pin input synchroniser
  // ----------------------------------------------------------------
  sync_2ff #(
    .RESET_VAL(1'b1)
  ) u_pin_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .d(rst_pin_in),
    .q(pin_sync)
  );

  // ----------------------------------------------------------------
  // Decoded events
  // ----------------------------------------------------------------
  assign running = (state_r == st_run);
  assign in_reset = (state_r == st_por) || (state_r == st_drive) || (state_r == st_ext);
  assign pin_drive = (state_r == st_por) || (state_r == st_drive);
  assign stop_phase = (state_r == st_stop) || (state_r == st_wake);
  assign wr_ok = avs_write && ack_r && avs_byteenable[0];
  assign misc_wr = wr_ok && (avs_address == `MISC_OFFSET);
  assign watchdog_enable_clear_bit_write1 = misc_wr && avs_writedata[`MISC_WATCHDOG_ENABLE_CLEAR_BIT_BIT];
  assign wait_enter = running && wait_active && !wait_d_r;
  assign halted = WAIT_HALTS && wait_active;
  assign tick = running && watchdog_enable_clear_bit_en_r && timer_carry7 && !halted;
  assign dog_fire = running && watchdog_enable_clear_bit_en_r && (div8_r == `DIV8_FINAL);
  assign stop_fire = running && stop_exec && watchdog_enable_clear_bit_en_r;
  assign stop_sleep = running && stop_exec && !watchdog_enable_clear_bit_en_r;

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r <= st_por;
      delay_r <= 12'h000;
    end else begin
      case (state_r)
        st_por: begin
          if (delay_r == STARTUP_CYC - 12'h001) begin
            state_r <= st_ext;
            delay_r <= 12'h000;
          end else begin
            delay_r <= delay_r + 12'h001;
          end
        end
        st_run: begin
          if (dog_fire || stop_fire) begin
            state_r <= st_drive;
            delay_r <= 12'h000;
          end else if (stop_sleep) begin
            state_r <= st_stop;
            delay_r <= 12'h000;
          end else if (!pin_sync) begin
            if (delay_r == EXT_MIN_CYC - 12'h001) begin
              state_r <= st_ext;
              delay_r <= 12'h000;
            end else begin
              delay_r <= delay_r + 12'h001;
            end
          end else begin
            delay_r <= 12'h000;
          end
        end
        st_drive: begin
          if (!pin_sync) begin
            if (delay_r == HOLD_CYC - 12'h001) begin
              state_r <= st_ext;
              delay_r <= 12'h000;
            end else begin
              delay_r <= delay_r + 12'h001;
            end
          end else begin
            delay_r <= 12'h000;
          end
        end
        st_ext: begin
          delay_r <= 12'h000;
          if (pin_sync) begin
            state_r <= st_run;
          end
        end
        st_stop: begin
          delay_r <= 12'h000;
          if (!pin_sync) begin
            state_r <= st_ext;
          end else if (stop_wake) begin
            state_r <= st_wake;
          end
        end
        st_wake: begin
          if (delay_r == STOP_WAKE_CYC - 12'h001) begin
            state_r <= st_run;
            delay_r <= 12'h000;
          end else begin
            delay_r <= delay_r + 12'h001;
          end
        end
        default: begin
          state_r <= st_por;
          delay_r <= 12'h000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Watchdog enable
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      watchdog_enable_clear_bit_en_r <= AUTO_ENABLE;
    end else if (in_reset) begin
      watchdog_enable_clear_bit_en_r <= AUTO_ENABLE;
    end else if (stop_phase) begin
      watchdog_enable_clear_bit_en_r <= 1'b0;
    end else if (watchdog_enable_clear_bit_write1) begin
      watchdog_enable_clear_bit_en_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Divider chain
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst || in_reset || stop_phase || !watchdog_enable_clear_bit_en_r) begin
      presc_r <= '0;
      div8_r <= 3'h0;
    end else if (wait_enter) begin
      presc_r <= '0;
      div8_r <= 3'h0;
    end else if (watchdog_enable_clear_bit_write1) begin
      div8_r <= 3'h0;
      if (tick) begin
        presc_r <= presc_r + 1'b1;
      end
    end else if (tick) begin
      presc_r <= presc_r + 1'b1;
      if (&presc_r) begin
        div8_r <= div8_r + 3'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wait_d_r <= 1'b0;
    end else begin
      wait_d_r <= running && wait_active;
    end
  end

  // ----------------------------------------------------------------
  // Reset cause
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      watchdog_enable_clear_bit_cause_r <= 1'b0;
      stop_cause_r <= 1'b0;
    end else if (dog_fire || stop_fire) begin
      watchdog_enable_clear_bit_cause_r <= 1'b1;
      stop_cause_r <= stop_fire && !dog_fire;
    end else if (running && !pin_sync) begin
      watchdog_enable_clear_bit_cause_r <= 1'b0;
      stop_cause_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Control bits
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      por_flag_r <= 1'b1;
    end else if (misc_wr && !avs_writedata[`MISC_POR_BIT]) begin
      por_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || in_reset || stop_phase) begin
      slow_mode_r <= 1'b0;
    end else if (misc_wr) begin
      slow_mode_r <= avs_writedata[`MISC_SLOW_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || in_reset) begin
      ext_irq_en_r <= 1'b1;
    end else if (misc_wr) begin
      ext_irq_en_r <= avs_writedata[`MISC_IRQEN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Effects handed to the other units
  // ----------------------------------------------------------------
  always_comb begin
    effects_nxt.timer_reset = in_reset;
    effects_nxt.cpu_restart = in_reset;
    effects_nxt.serial_reset = in_reset;
    effects_nxt.osc_off = (state_r == st_por) || stop_phase;
    effects_nxt.clk_clear = (state_r == st_por) || stop_phase;
    effects_nxt.analog_nvm_reset = in_reset || stop_phase;
    effects_nxt.i_bit_clear = wait_enter || stop_sleep;
    effects_nxt.timer_load = `TIMER_LOAD;
    effects_nxt.stack_init = `STACK_INIT;
    effects_nxt.start_vector = `START_VECTOR;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      effects_r.timer_reset <= 1'b1;
      effects_r.cpu_restart <= 1'b1;
      effects_r.serial_reset <= 1'b1;
      effects_r.osc_off <= 1'b1;
      effects_r.clk_clear <= 1'b1;
      effects_r.analog_nvm_reset <= 1'b1;
      effects_r.i_bit_clear <= 1'b0;
      effects_r.timer_load <= `TIMER_LOAD;
      effects_r.stack_init <= `STACK_INIT;
      effects_r.start_vector <= `START_VECTOR;
    end else begin
      effects_r <= effects_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave, one wait state per access
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      readdata_r <= 32'h0000_0000;
    end else if (avs_read && !ack_r) begin
      readdata_r <= 32'h0000_0000;
      case (avs_address)
        `MISC_OFFSET: begin
          readdata_r[`MISC_POR_BIT] <= por_flag_r;
          readdata_r[`MISC_IRQEN_BIT] <= ext_irq_en_r;
          readdata_r[`MISC_SLOW_BIT] <= slow_mode_r;
          readdata_r[`MISC_WATCHDOG_ENABLE_CLEAR_BIT_BIT] <= watchdog_enable_clear_bit_en_r;
        end
        `STAT_OFFSET: begin
          readdata_r[`STAT_CNT_MSB:`STAT_CNT_LSB] <= div8_r;
          readdata_r[`STAT_PIN_BIT] <= pin_drive;
          readdata_r[`STAT_WDRST_BIT] <= watchdog_enable_clear_bit_cause_r;
          readdata_r[`STAT_STOPRST_BIT] <= stop_cause_r;
          readdata_r[`STAT_EN_BIT] <= watchdog_enable_clear_bit_en_r;
        end
        default: begin
          readdata_r <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign avs_readdata = readdata_r;
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe_n = !pin_drive;
  assign chip_reset = in_reset;
  assign slow_mode_bit = slow_mode_r;
  assign ext_irq_enable = ext_irq_en_r;
  assign effects = effects_r;

endmodule

// ==== tb/cop_watchdog_reset_control_properties.sv ====
`timescale 1ns/1ps
module cop_watchdog_reset_control_checker #(
  parameter bit AUTO_ENABLE = 1'b0
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic rst_pin_in,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe_n,
  input wire logic timer_carry7,
  input wire logic stop_exec,
  input wire logic stop_wake,
  input wire logic wait_active,
  input wire logic chip_reset,
  input wire logic slow_mode_bit,
  input wire logic ext_irq_enable,
  input wire cop_watchdog_enable_clear_bit_pkg::reset_effects_type effects
);
  import cop_watchdog_enable_clear_bit_pkg::*;
  // ----------------------------------------------------------------
  // Watchdog enable and carries counted since the last clear
  // ----------------------------------------------------------------
  logic en_r;
  logic wait_q;
  logic [15:0] car_r;
  wire en_wr = avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0]
    && avs_writedata[0];
  always_ff @(posedge clock) begin
    if (sys_rst || chip_reset) en_r <= AUTO_ENABLE;
    else if (en_wr) en_r <= 1'b1;
  end
  always_ff @(posedge clock) begin
    wait_q <= wait_active;
  end
  always_ff @(posedge clock) begin
    if (sys_rst || chip_reset || en_wr || !en_r || (wait_active && !wait_q)) car_r <= 16'h0;
    else if (timer_carry7 && car_r != 16'hffff) car_r <= car_r + 16'h1;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_sleep;
    ##1 effects.i_bit_clear ##1 effects.osc_off [*4];
  endsequence
  sequence s_pin_up;
    (chip_reset && rst_pin_oe_n && rst_pin_in) [*3];
  endsequence
  property p_bus_ack;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  property p_od_drive;
    !rst_pin_oe_n |-> chip_reset && !rst_pin_out;
  endproperty
  property p_resume;
    s_pin_up |-> ##[0:1] !chip_reset;
  endproperty
  property p_low_hold;
    $rose(rst_pin_oe_n) |-> !$past(rst_pin_in, 1) && !$past(rst_pin_in, 2) && !$past(rst_pin_in, 3);
  endproperty
  property p_timeout;
    $fell(rst_pin_oe_n) && !$past(chip_reset) && !$past(stop_exec, 1) && !$past(stop_exec, 2)
      && !$past(stop_exec, 3) |-> car_r > 16'd6144 && car_r <= 16'd7170;
  endproperty
  property p_stop_dog;
    stop_exec && en_r && !chip_reset |-> ##[1:3] !rst_pin_oe_n;
  endproperty
  property p_stop_osc;
    stop_exec && en_r && !chip_reset |-> ##1 (!effects.osc_off) [*8];
  endproperty
  property p_stop_sleep;
    stop_exec && !en_r && !chip_reset |-> s_sleep;
  endproperty
  property p_wait_ibit;
    $rose(wait_active) && !chip_reset |-> ##1 effects.i_bit_clear;
  endproperty
  property p_reset_fx;
    $rose(chip_reset) |-> ##[0:2] (effects.timer_reset && effects.cpu_restart && effects.serial_reset
      && effects.timer_load == 16'hfffc && effects.stack_init == 8'hff
      && effects.start_vector == 16'h1ffe);
  endproperty
  property p_forced_ctrl;
    $past(chip_reset) && chip_reset |-> ext_irq_enable && !slow_mode_bit;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("waitrequest held too long");
  a_od_drive: assert property (p_od_drive) else $error("pin driven outside reset");
  a_resume: assert property (p_resume) else $error("no resume after pin high");
  a_low_hold: assert property (p_low_hold) else $error("pin released too early");
  a_timeout: assert property (p_timeout) else $error("watchdog timeout count wrong");
  a_stop_dog: assert property (p_stop_dog) else $error("stop did not reset");
  a_stop_osc: assert property (p_stop_osc) else $error("oscillator stopped");
  a_stop_sleep: assert property (p_stop_sleep) else $error("stop sleep wrong");
  a_wait_ibit: assert property (p_wait_ibit) else $error("wait mask not cleared");
  a_reset_fx: assert property (p_reset_fx) else $error("reset effects wrong");
  a_forced_ctrl: assert property (p_forced_ctrl) else $error("control not forced");
endmodule

bind cop_watchdog_reset_control cop_watchdog_reset_control_checker #(
  .AUTO_ENABLE(AUTO_ENABLE)) u_chk (.clock(clock), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rst_pin_in(rst_pin_in),
  .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n), .timer_carry7(timer_carry7),
  .stop_exec(stop_exec), .stop_wake(stop_wake), .wait_active(wait_active),
  .chip_reset(chip_reset), .slow_mode_bit(slow_mode_bit), .ext_irq_enable(ext_irq_enable),
  .effects(effects));

// ==== tb/reset_pin_model.sv ====
`timescale 1ns/1ps
module reset_pin_model (
  input wire logic clock,
  input wire logic oe_n,
  input wire logic drive_level,
  input wire logic ext_low,
  input wire logic stretch_en,
  output logic pin
);
  // ----------------------------------------------------------------
  // Slow external RC keeps the line low after the device lets go
  // ----------------------------------------------------------------
  logic [4:0] hold_r = 5'h0;
  always_ff @(posedge clock) begin
    if (!oe_n) hold_r <= stretch_en ? 5'h14 : 5'h0;
    else if (hold_r != 5'h0) hold_r <= hold_r - 5'h1;
  end
  // Pull-up unless someone pulls low
  assign pin = ((!oe_n && !drive_level) || ext_low || hold_r != 5'h0) ? 1'b0 : 1'b1;
endmodule

// ==== tb/tb_cop_watchdog_reset_control.sv ====
`timescale 1ns/1ps
module tb_cop_watchdog_reset_control;
  import cop_watchdog_enable_clear_bit_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0;
  logic avs_read = 1'b0, avs_write = 1'b0, timer_carry7 = 1'b0, stop_exec = 1'b0;
  logic stop_wake = 1'b0, wait_active = 1'b0, ext_low = 1'b0, stretch_en = 1'b0;
  logic carry_on = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, rst_pin, rst_pin_out, rst_pin_oe_n, chip_reset, slow_mode_bit;
  logic ext_irq_enable;
  reset_effects_type effects;
  logic [31:0] exp_q[$], msk_q[$];
  logic [15:0] seed = 16'h6819;
  logic [7:0] v;
  int n_errors = 0, samples_checked = 0, cyc = 0, k, ncar;

  initial begin
    forever #12.5 clock = ~clock;
  end

  cop_watchdog_reset_control #(.LONG_STARTUP(1'b0)) u_cop_watchdog_reset_control (
    .clock(clock), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rst_pin_in(rst_pin),
    .rst_pin_out(rst_pin_out), .rst_pin_oe_n(rst_pin_oe_n), .timer_carry7(timer_carry7),
    .stop_exec(stop_exec), .stop_wake(stop_wake), .wait_active(wait_active),
    .chip_reset(chip_reset), .slow_mode_bit(slow_mode_bit), .ext_irq_enable(ext_irq_enable),
    .effects(effects));
  reset_pin_model u_reset_pin_model (.clock(clock), .oe_n(rst_pin_oe_n),
    .drive_level(rst_pin_out), .ext_low(ext_low), .stretch_en(stretch_en), .pin(rst_pin));

  always @(posedge clock) begin
    timer_carry7 <= carry_on && !timer_carry7;
  end

  function automatic logic [15:0] xs(input logic [15:0] s);
    s = s ^ (s << 7);
    s = s ^ (s >> 9);
    return s ^ (s << 8);
  endfunction

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask

  // ----------------------------------------------------------------
  // Read results are matched against the oldest noted expectation
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      chk("readdata", exp_q.pop_front(), avs_readdata & msk_q.pop_front());
    end
  end

  task bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge clock);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, 8'h0, 4'hf);
  endtask

  task pulse_stop;
    @(posedge clock);
    stop_exec <= 1'b1;
    @(posedge clock);
    stop_exec <= 1'b0;
  endtask

  task wait_run;
    int i;
    for (i = 0; i < 9000 && chip_reset !== 1'b0; i++) @(posedge clock);
    chk("chip_reset", 32'h0, {31'h0, chip_reset});
  endtask

  task results;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      results;
    end
  end

  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    wait_run;
    rd(4'h0, 32'h90, 32'hff);
    wr(4'h0, 8'h80);
    rd(4'h0, 32'h80, 32'hff);
    bus(1'b1, 4'h0, 8'h12, 4'h0);
    rd(4'h0, 32'h80, 32'hff);
    wr(4'h8, 8'hff);
    rd(4'h8, 32'h0, 32'hffffffff);
    for (k = 0; k < 4; k++) begin
      seed = xs(seed);
      v = seed[7:0] & 8'h12;
      wr(4'h0, v);
      rd(4'h0, {24'h0, v}, 32'h93);
      chk("slow_mode_bit", {31'h0, v[1]}, {31'h0, slow_mode_bit});
    end
    carry_on <= 1'b1;
    repeat (3000) @(posedge clock);
    rd(4'h4, 32'h0, 32'h47);
    wr(4'h0, 8'h01);
    wr(4'h0, 8'h00);
    rd(4'h4, 32'h40, 32'h40);
    repeat (2100) @(posedge clock);
    carry_on <= 1'b0;
    wr(4'h0, 8'h01);
    rd(4'h4, 32'h0, 32'h7);
    carry_on <= 1'b1;
    ncar = 0;
    for (k = 0; k < 20000 && rst_pin_oe_n !== 1'b0; k++) begin
      @(posedge clock);
      if (timer_carry7 === 1'b1) ncar++;
    end
    chk("timeout_carries", 32'h1, {31'h0, ncar > 6144 && ncar <= 7170});
    carry_on <= 1'b0;
    stretch_en <= 1'b1;
    wait_run;
    stretch_en <= 1'b0;
    rd(4'h4, 32'h10, 32'h58);
    rd(4'h0, 32'h10, 32'h93);
    wr(4'h0, 8'h01);
    pulse_stop;
    repeat (3) @(posedge clock);
    wait_run;
    rd(4'h4, 32'h30, 32'h70);
    wr(4'h0, 8'h02);
    pulse_stop;
    repeat (10) @(posedge clock);
    chk("osc_off", 32'h1, {31'h0, effects.osc_off});
    chk("clk_clear", 32'h1, {31'h0, effects.clk_clear});
    chk("analog_nvm_reset", 32'h1, {31'h0, effects.analog_nvm_reset});
    @(posedge clock);
    stop_wake <= 1'b1;
    @(posedge clock);
    stop_wake <= 1'b0;
    for (k = 0; k < 6000 && effects.osc_off !== 1'b0; k++) @(posedge clock);
    chk("osc_hold", 32'h1, {31'h0, k >= 4062 && k <= 4068});
    rd(4'h0, 32'h0, 32'h02);
    wr(4'h0, 8'h01);
    carry_on <= 1'b1;
    repeat (2200) @(posedge clock);
    wait_active <= 1'b1;
    repeat (4) @(posedge clock);
    carry_on <= 1'b0;
    repeat (2) @(posedge clock);
    rd(4'h4, 32'h40, 32'h47);
    wait_active <= 1'b0;
    @(posedge clock);
    ext_low <= 1'b1;
    @(posedge clock);
    ext_low <= 1'b0;
    repeat (6) @(posedge clock);
    chk("short_pulse", 32'h0, {31'h0, chip_reset});
    ext_low <= 1'b1;
    repeat (6) @(posedge clock);
    chk("ext_reset", 32'h1, {31'h0, chip_reset});
    ext_low <= 1'b0;
    @(posedge clock);
    wait_run;
    rd(4'h4, 32'h0, 32'h40);
    rd(4'h0, 32'h10, 32'h93);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    wait_run;
    rd(4'h0, 32'h90, 32'hff);
    repeat (4) @(posedge clock);
    results;
  end
endmodule
